// >>> dv/wdt_top_properties.sv
// Checker of the watchdog bus answers and overflow outputs
`timescale 1ns/100ps
module wdt_top_properties
	import wdt_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        int_reset_o,
	input wire logic        overflow_irq_pulse_o,
	input wire logic        overflow_out_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A fresh request is taken only while enabled
	logic req;
	assign req = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	property p_ack_next; req |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_once; ce_i && wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_idle; ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
	// Clock enable low freezes the bus side as well
	property p_freeze; !ce_i |=> $stable(wb_ack_o); endproperty
	a_freeze: assert property (p_freeze) else $error("ack moved while frozen");
	property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	property p_key_zero; req && !wb_we_i && wb_adr_i == {1'b0, OFS_CLOCK} |=> wb_dat_o[15:6] == 10'h0; endproperty
	a_key_zero: assert property (p_key_zero) else $error("clock key read back");
	property p_stat_bits; req && !wb_we_i && wb_adr_i == {1'b0, OFS_STATUS} |=> wb_dat_o[31:1] == 31'h0; endproperty
	a_stat_bits: assert property (p_stat_bits) else $error("status upper bits set");
	property p_irq_pulse; ce_i && overflow_irq_pulse_o |=> !overflow_irq_pulse_o; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
	property p_rst_pulse; ce_i && int_reset_o |=> !int_reset_o; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
	property p_pin_low; $fell(overflow_out_n_o) |-> !overflow_out_n_o [*8] ##1 overflow_out_n_o; endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin low time wrong");
endmodule

// >>> dv/wdt_top_test.sv
// Self-checking bench of the watchdog registers and overflow actions
`timescale 1ns/100ps
module wdt_top_test;
	import wdt_pkg::*;
	// Overflow time from a restart with zero preload at divide by 8
	localparam int T_OVF = (int'(LOW_PRELOAD) + 1) * (int'(DIV8) + 1);
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        ext_reset_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [4:0]  wb_adr_i = 5'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        int_reset_o;
	logic        overflow_irq_pulse_o;
	logic        overflow_out_n_o;
	logic        irq_o;
	logic [31:0] q;          // Last read word
	int          errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          t0;
	wdt_top uut (.clk_i, .rst_i, .ce_i, .ext_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .int_reset_o, .overflow_irq_pulse_o, .overflow_out_n_o, .irq_o);
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Ceiling covers two overflow periods plus register traffic
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			conclude();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One classic cycle; held until ack is sampled high
	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] adr, input string name, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check(name, q, exp);
	endtask
	// Waits for the overflow pulse; the global ceiling bounds it
	task automatic wait_ovf();
		do @(posedge clk_i); while (overflow_irq_pulse_o !== 1'b1);
	endtask
	task automatic t_reset();
		rd({1'b0, OFS_ACTION}, "action", 32'h0);
		rd({1'b0, OFS_CLOCK}, "clock", 32'h0);
		rd({1'b0, OFS_STATUS}, "status", 32'h0);
		wb(1'b1, 5'h1c, 32'hffff_ffff);
		rd(5'h1c, "unmapped", 32'h0);
		check("pin", overflow_out_n_o, 32'h1);
		check("irq idle", irq_o, 32'h0);
		// A request held while the clock enable is low must wait for it
		ce_i <= 1'b0;
		fork
			rd({1'b0, OFS_STATUS}, "frozen read", 32'h0);
			begin
				repeat (4) @(posedge clk_i);
				check("frozen ack", wb_ack_o, 32'h0);
				ce_i <= 1'b1;
			end
		join
		$display("reset test done");
	endtask
	task automatic t_keys();
		wb(1'b1, {1'b0, OFS_ACTION}, 32'h1115);
		rd({1'b0, OFS_ACTION}, "action bad key", 32'h0);
		wb(1'b1, {1'b0, OFS_ACTION}, 32'h2340);
		rd({1'b0, OFS_ACTION}, "action off", 32'h0);
		wb(1'b1, {1'b0, OFS_CLOCK}, 32'h3b3c);
		rd({1'b0, OFS_CLOCK}, "clock bad key", 32'h0);
		wb_sel_i <= 4'h3;
		wb(1'b1, {1'b0, OFS_CLOCK}, 32'h373c);
		wb_sel_i <= 4'hf;
		rd({1'b0, OFS_CLOCK}, "clock partial lanes", 32'h0);
		wb(1'b1, {1'b0, OFS_CLOCK}, 32'h373c);
		rd({1'b0, OFS_CLOCK}, "clock good key", 32'h3c);
		wb(1'b1, {1'b0, OFS_CLOCK}, 32'h3700);
		rd({1'b0, OFS_CLOCK}, "clock divide by 8", 32'h0);
		wb(1'b1, {1'b0, OFS_RESTART}, 32'hc070);
		rd(5'h10, "restart bad key", 32'h0);
		wb(1'b1, {1'b0, OFS_RESTART}, 32'hc071);
		rd(5'h10, "restart event", 32'h2);
		wb(1'b1, 5'h14, 32'h3);
		rd(5'h10, "events cleared", 32'h0);
		$display("key test done");
	endtask
	task automatic t_overflow();
		wb(1'b1, 5'h18, 32'h1);
		wb(1'b1, {1'b0, OFS_RESTART}, 32'hc071);
		t0 = cycles;
		wb(1'b1, {1'b0, OFS_ACTION}, 32'h234f);
		rd({1'b0, OFS_ACTION}, "action all on", 32'hf);
		wait_ovf();
		check("reset pulse", int_reset_o, 32'h1);
		check("pin low", overflow_out_n_o, 32'h0);
		check("timeout", 32'((cycles - t0) inside {[T_OVF - 8 : T_OVF + 16]}), 32'h1);
		rd({1'b0, OFS_STATUS}, "flag set", 32'h1);
		check("irq on", irq_o, 32'h1);
		// Both the overflow and the earlier restart events are pending here
		wb(1'b1, 5'h14, 32'h3);
		rd(5'h10, "irq bank", 32'h0);
		check("irq off", irq_o, 32'h0);
		wb(1'b1, {1'b0, OFS_ACTION}, 32'h2340);
		wb(1'b1, {1'b0, OFS_RESTART}, 32'hc071);
		rd({1'b0, OFS_STATUS}, "flag restart", 32'h0);
		wb(1'b1, {1'b0, OFS_ACTION}, 32'h2345);
		rd({1'b0, OFS_ACTION}, "action irq only", 32'h5);
		wait_ovf();
		check("no reset pulse", int_reset_o, 32'h0);
		check("pin idle", overflow_out_n_o, 32'h1);
		rd({1'b0, OFS_STATUS}, "flag again", 32'h1);
		check("irq again", irq_o, 32'h1);
		@(posedge clk_i) ext_reset_i <= 1'b1;
		@(posedge clk_i) ext_reset_i <= 1'b0;
		rd({1'b0, OFS_STATUS}, "flag ext", 32'h0);
		$display("overflow test done");
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_keys();
		t_overflow();
		conclude();
	end
endmodule
bind wdt_top wdt_top_properties chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .int_reset_o, .overflow_irq_pulse_o, .overflow_out_n_o);

// >>> pkg/wdt_pkg.sv
// Package with register map, field layout and timing constants of the watchdog
package wdt_pkg;
	// Register byte offsets
	localparam logic [3:0] OFS_ACTION  = 4'h0;
	localparam logic [3:0] OFS_CLOCK   = 4'h4;
	localparam logic [3:0] OFS_RESTART = 4'h8;
	localparam logic [3:0] OFS_STATUS  = 4'hc;
	localparam logic [3:0] OFS_IRQ_ST  = 4'h0;
	localparam logic [3:0] OFS_IRQ_CLR = 4'h4;
	localparam logic [3:0] OFS_IRQ_EN  = 4'h8;
	// Bank select: address bit 4 picks the interrupt bank
	localparam int         BANK_BIT    = 4;
	// Access keys
	localparam logic [11:0] ACTION_KEY  = 12'h234;
	localparam logic [11:0] CLOCK_KEY   = 12'h06e;
	localparam logic [15:0] RESTART_KEY = 16'hc071;
	// Field positions
	localparam int KEY_LSB      = 4;
	localparam int CLOCK_KEY_LSB = 7;
	localparam int PRELOAD_LSB  = 2;
	// Reset values
	localparam logic [3:0]  ACTION_RST  = 4'h0;
	localparam logic [5:0]  CLOCK_RST   = 6'h00;
	localparam logic [11:0] LOW_PRELOAD = 12'hfff;
	// Divider terminal counts, ratio minus one, per tick source code
	localparam logic [9:0]  DIV8    = 10'd7;
	localparam logic [9:0]  DIV32   = 10'd31;
	localparam logic [9:0]  DIV128  = 10'd127;
	localparam logic [9:0]  DIV1024 = 10'd1023;
	// Overflow pin low time in system clocks
	localparam int          PIN_LOW_CYCLES = 8;
	localparam logic [3:0]  PIN_LOW_LAST   = 4'(PIN_LOW_CYCLES - 1);
	// Overflow action enables
	typedef struct packed {
		logic pin_action_on;
		logic interrupt_action_on;
		logic reset_action_on;
		logic watchdog_on;
	} wdt_action_s;
	// Clock setup fields
	typedef struct packed {
		logic [3:0] high_preload_nibble;
		logic [1:0] tick_source_select;
	} wdt_clock_s;
	// Interrupt bank events: bit0 overflow, bit1 restart
	localparam int NUM_EVENTS = 2;
endpackage

// >>> rtl/wdt_tick.sv
// Prescaler producing one tick per selected system clock division
`timescale 1ns/100ps
module wdt_tick (
	input  wire logic       clk_i,    // System clock
	input  wire logic       rst_i,    // Synchronous reset
	input  wire logic       ce_i,     // Clock enable
	input  wire logic       clear_i,  // Restart the prescaler phase
	input  wire logic [1:0] sel_i,    // Tick source select
	output logic            tick_o    // One-cycle tick
);
	import wdt_pkg::*;

	logic [9:0] cnt;       // Prescale count
	logic [9:0] next_cnt;
	logic [9:0] limit;     // Terminal count of selected ratio

	// Divide ratio lookup
	always_comb begin
		case (sel_i)
			2'b00:   limit = DIV8;
			2'b01:   limit = DIV32;
			2'b10:   limit = DIV128;
			default: limit = DIV1024;
		endcase
		next_cnt = cnt;
		tick_o   = 1'b0;
		// Clearing on restart keeps the first interval full length
		if (clear_i) begin
			next_cnt = 10'h000;
		end else if (cnt >= limit) begin
			next_cnt = 10'h000;
			tick_o   = 1'b1;
		end else begin
			next_cnt = cnt + 10'h001;
		end
	end

	// Count register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 10'h000;
		end else if (ce_i) begin
			cnt <= next_cnt;
		end
	end
endmodule

// >>> rtl/wdt_top.sv
// Watchdog timer with keyed setup, restart and overflow actions on Wishbone
// Contract
// - Tick is system clock over 8/32/128/1024
// - Sixteen-bit down counter reloaded on restart
// - Overflow raises reset, irq pulse, eight-cycle pin
// - Reload low twelve ones, high preload nibble
// - Clock setup written only with key 06e
// - Restart only on key c071
// - Overflow flag sticky until restart or reset
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module wdt_top (
	input  wire logic        clk_i,           // System clock, 25 MHz
	input  wire logic        rst_i,           // Synchronous reset, active high
	input  wire logic        ce_i,            // Clock enable, freezes all state when low
	input  wire logic        ext_reset_i,     // External reset seen by the flag
	input  wire logic        wb_cyc_i,        // Wishbone cycle
	input  wire logic        wb_stb_i,        // Wishbone strobe
	input  wire logic        wb_we_i,         // Wishbone write
	input  wire logic [4:0]  wb_adr_i,        // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,        // Wishbone write data
	output logic [31:0]      wb_dat_o,        // Wishbone read data
	output logic             wb_ack_o,        // Wishbone acknowledge
	output logic             int_reset_o,     // Internal reset request pulse
	output logic             overflow_irq_pulse_o, // One-cycle overflow pulse
	output logic             overflow_out_n_o,     // Overflow pin, active low
	output logic             irq_o            // Level interrupt
);
	import wdt_pkg::*;

	wdt_action_s action;            // Overflow action register
	wdt_action_s next_action;
	wdt_clock_s  clk_setup;         // Clock setup register
	wdt_clock_s  next_clk_setup;
	logic [15:0] count;             // Down counter
	logic [15:0] next_count;
	logic        overflow_flag;     // Sticky overflow flag
	logic        next_overflow_flag;
	logic [3:0]  pin_cnt;           // Remaining low time of overflow pin
	logic [3:0]  next_pin_cnt;
	logic        pin_low;           // Pin currently driven low
	logic        next_pin_low;
	logic        next_int_reset;
	logic        next_irq_pulse;
	logic [NUM_EVENTS-1:0] irq_status; // Sticky interrupt events
	logic [NUM_EVENTS-1:0] next_irq_status;
	logic [NUM_EVENTS-1:0] irq_enable; // Interrupt enables
	logic [NUM_EVENTS-1:0] next_irq_enable;
	logic        next_irq;
	logic [31:0] next_dat;
	logic        next_ack;
	logic        tick;              // Prescaled tick
	logic        wr;                // Write strobe this cycle
	logic        rd;                // Read strobe this cycle
	logic        restart;           // Keyed restart accepted
	logic        overflow;          // Overflow event this cycle
	logic        full_word;         // All byte lanes written

	// Byte lanes: keyed registers need whole-word writes, so partial ones are ignored
	function automatic logic is_reg(input logic [4:0] adr, input logic bank, input logic [3:0] ofs);
		return (adr[BANK_BIT] == bank) && (adr[3:0] == ofs);
	endfunction

	// Reload word: low twelve bits all ones, upper nibble from the preload field
	function automatic logic [15:0] reload_value(input logic [3:0] nibble);
		return {nibble, LOW_PRELOAD};
	endfunction

	// Ack high masks the request that the master still holds, so no access is served twice
	assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd        = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign full_word = (wb_sel_i == 4'hf);
	// Restart key fills the low half-word; the upper half is ignored
	assign restart   = wr && full_word && is_reg(wb_adr_i, 1'b0, OFS_RESTART)
	                   && (wb_dat_i[15:0] == RESTART_KEY);

	// Prescaler, restarted with the counter
	// A source change mid-interval ends the interval at once if the count is past the new limit
	wdt_tick u_tick (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.clear_i (restart),
		.sel_i   (clk_setup.tick_source_select),
		.tick_o  (tick)
	);

	// Overflow happens on a tick with the counter already at zero
	// A restart in the same cycle takes precedence, so a late restart still saves the system
	assign overflow = action.watchdog_on && tick && (count == 16'h0000) && !restart;

	// Register, counter and action next-state logic
	always_comb begin
		next_action        = action;
		next_clk_setup     = clk_setup;
		next_count         = count;
		next_overflow_flag = overflow_flag;
		next_pin_cnt       = pin_cnt;
		next_pin_low       = pin_low;
		next_int_reset     = 1'b0;
		next_irq_pulse     = 1'b0;
		// Overflow action register, keyed
		if (wr && full_word && is_reg(wb_adr_i, 1'b0, OFS_ACTION)
		    && (wb_dat_i[15:KEY_LSB] == ACTION_KEY)) begin
			next_action = wdt_action_s'(wb_dat_i[3:0]);
		end
		// Clock setup register, keyed; the key sits above reserved bit six, which is ignored
		// A wrong key leaves both fields untouched, so a stray write cannot slow the watchdog
		if (wr && full_word && is_reg(wb_adr_i, 1'b0, OFS_CLOCK)
		    && (wb_dat_i[15:CLOCK_KEY_LSB] == 9'(CLOCK_KEY))) begin
			next_clk_setup = wdt_clock_s'(wb_dat_i[5:0]);
		end
		// Counter: restart reloads, tick decrements
		if (restart) begin
			next_count = reload_value(clk_setup.high_preload_nibble);
		end else if (action.watchdog_on && tick && (count != 16'h0000)) begin
			next_count = count - 16'h0001;
		end else if (overflow) begin
			next_count = reload_value(clk_setup.high_preload_nibble); // Free-run after overflow
		end
		// Sticky flag: set wins over external reset clear; restart blocks the set
		if (overflow) begin
			next_overflow_flag = 1'b1;
		end else if (restart || ext_reset_i) begin
			next_overflow_flag = 1'b0;
		end
		// Overflow actions
		// Pulses are registered, so they lag the overflow edge by one cycle
		// Pin counter runs down from the last index; the cycle at zero is the last low one
		if (overflow) begin
			next_int_reset = action.reset_action_on;
			next_irq_pulse = action.interrupt_action_on;
			if (action.pin_action_on) begin
				next_pin_low = 1'b1;
				next_pin_cnt = PIN_LOW_LAST;
			end
		end else if (pin_low) begin
			if (pin_cnt == 4'h0) begin
				next_pin_low = 1'b0;
			end else begin
				next_pin_cnt = pin_cnt - 4'h1;
			end
		end
	end

	// Interrupt bank and bus answer next-state logic
	always_comb begin
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		next_dat        = 32'h0000_0000;
		next_ack        = wb_cyc_i && wb_stb_i && !wb_ack_o;
		// Clear first, so a same-cycle event set wins
		// Write data bits above the event count are ignored by clear and enable
		if (wr && is_reg(wb_adr_i, 1'b1, OFS_IRQ_CLR) && wb_sel_i[0]) begin
			next_irq_status = irq_status & ~wb_dat_i[NUM_EVENTS-1:0];
		end
		next_irq_status = next_irq_status | {restart, overflow};
		if (wr && is_reg(wb_adr_i, 1'b1, OFS_IRQ_EN) && wb_sel_i[0]) begin
			next_irq_enable = wb_dat_i[NUM_EVENTS-1:0];
		end
		// Level output from next values, so it follows the status with no extra cycle
		next_irq = |(next_irq_status & next_irq_enable);
		// Read mux; keys read as zero, unmapped reads zero
		if (rd) begin
			if (is_reg(wb_adr_i, 1'b0, OFS_ACTION)) begin
				// Action key field is never stored, so it reads as zero
				next_dat = {28'h0, action};
			end else if (is_reg(wb_adr_i, 1'b0, OFS_CLOCK)) begin
				next_dat = {26'h0, clk_setup};
			end else if (is_reg(wb_adr_i, 1'b0, OFS_STATUS)) begin
				next_dat = {31'h0, overflow_flag};
			end else if (is_reg(wb_adr_i, 1'b1, OFS_IRQ_ST)) begin
				next_dat = {30'h0, irq_status};
			end else if (is_reg(wb_adr_i, 1'b1, OFS_IRQ_EN)) begin
				next_dat = {30'h0, irq_enable};
			end else begin
				next_dat = 32'h0000_0000;
			end
		end
	end

	// State registers
	// Reset wins over the clock enable, so a frozen block can still be brought to a known state
	// Counter resets to the reload value of a zero preload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			action               <= wdt_action_s'(ACTION_RST);
			clk_setup            <= wdt_clock_s'(CLOCK_RST);
			count                <= {CLOCK_RST[5:2], LOW_PRELOAD};
			overflow_flag        <= 1'b0;
			pin_cnt              <= 4'h0;
			pin_low              <= 1'b0;
			overflow_out_n_o     <= 1'b1;
			int_reset_o          <= 1'b0;
			overflow_irq_pulse_o <= 1'b0;
			irq_status           <= '0;
			irq_enable           <= '0;
			irq_o                <= 1'b0;
			wb_dat_o             <= 32'h0000_0000;
			wb_ack_o             <= 1'b0;
		end else if (ce_i) begin
			action               <= next_action;
			clk_setup            <= next_clk_setup;
			count                <= next_count;
			overflow_flag        <= next_overflow_flag;
			pin_cnt              <= next_pin_cnt;
			pin_low              <= next_pin_low;
			overflow_out_n_o     <= !next_pin_low;
			int_reset_o          <= next_int_reset;
			overflow_irq_pulse_o <= next_irq_pulse;
			irq_status           <= next_irq_status;
			irq_enable           <= next_irq_enable;
			irq_o                <= next_irq;
			wb_dat_o             <= next_dat;
			wb_ack_o             <= next_ack;
		end
	end
endmodule
